// *** inc/tch_pkg.sv ***
// constants and types of the tape command and status handler
// assumes one clock, APB register access, tape interface on the same clock
// Functional notes
// - load (18h) brings tape to BOT, then medium change is watched
// - tape reset (1Ch) initializes the drive, third init step
// - retension (1Dh): forward to EOT off-line, then rewind to BOT
// - long-term: complete status and first irq at start, second at end
// - off-line end while busy: posted only after host clears flag
// - read status (1Eh) and every tape op copy drive status
// - terminate (1Fh): write ends with file mark, aborted read rewinds
// - modifier word from bytes 12-13, one bit each, active high
// - suppress bit drops short irq and first long irq only
// - inhibit-retries bit: single hard disk transfer attempt
// - linear bit: buffer pointer is 24-bit linear, byte 21 zero
// - bypass-test bit skips ram test when initializing disk 0
// - long-buffer bit sends long buffer, overwriting short buffer
// - motor bit drives motor-on for 8-inch flexible drives
// - checksum bit limits diagnostic to rom checksum
// - restore bit limits diagnostic to heads back to cylinder 0
// - short-term status at first irq, long-term at off-line end
// - op status: summary 3..0, unit 5..4, hard 6, any error 7
// - status condensed into op status byte before the interrupt
// - any set bit in detailed bytes 0..2 sets op status bit 7
package tch_pkg;
	// register byte addresses
	localparam logic [7:0] ADR_PARAM   = 8'h00;
	localparam logic [7:0] ADR_MODIFY  = 8'h04;
	localparam logic [7:0] ADR_BUFPTR  = 8'h08;
	localparam logic [7:0] ADR_CMD     = 8'h0c;
	localparam logic [7:0] ADR_OPSTAT  = 8'h10;
	localparam logic [7:0] ADR_SHORT0  = 8'h14;
	localparam logic [7:0] ADR_LONG0   = 8'h20;
	// opstat register fields, reset values and bad-function status
	localparam int         OPS_FLAG    = 8;
	localparam int         OPS_BUSY    = 9;
	localparam int         OPS_PEND    = 10;
	localparam logic [7:0] OPSTAT_RST  = 8'h00;
	localparam logic [95:0] STAT_RST   = 96'h0;
	localparam logic [95:0] STAT_BADFN = 96'h1;
	// modifier bit positions
	localparam int MOD_SUPP  = 0;
	localparam int MOD_NORTY = 1;
	localparam int MOD_DELDT = 2;
	localparam int MOD_LIN   = 3;
	localparam int MOD_BYPAS = 4;
	localparam int MOD_LONG  = 5;
	localparam int MOD_MOTOR = 6;
	localparam int MOD_CKSUM = 7;
	localparam int MOD_RESTR = 8;
	// device codes
	localparam logic [15:0] DEV_HARD = 16'h0000;
	localparam logic [15:0] DEV_FLEX = 16'h0003;
	localparam logic [15:0] DEV_TAPE = 16'h0004;
	// function codes
	localparam logic [7:0] FN_INIT    = 8'h00;
	localparam logic [7:0] FN_XSTAT   = 8'h01;
	localparam logic [7:0] FN_DIAG    = 8'h03;
	localparam logic [7:0] FN_RDDATA  = 8'h04;
	localparam logic [7:0] FN_WRDATA  = 8'h06;
	localparam logic [7:0] FN_REWIND  = 8'h11;
	localparam logic [7:0] FN_SPACEFM = 8'h12;
	localparam logic [7:0] FN_ERASE   = 8'h17;
	localparam logic [7:0] FN_LOAD    = 8'h18;
	localparam logic [7:0] FN_TRESET  = 8'h1c;
	localparam logic [7:0] FN_RETEN   = 8'h1d;
	localparam logic [7:0] FN_RDSTAT  = 8'h1e;
	localparam logic [7:0] FN_TERM    = 8'h1f;
	// request to the tape interface
	typedef struct packed {
		logic [7:0] code;
		logic [1:0] unit;
		logic       offline;
		logic       fm_write;
		logic       rewind;
	} tch_tif_req_t;
	typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT, ST_POST} tch_state_t;
endpackage

// *** rtl/tch_core.sv ***
// tape command interpreter with short and long term status posting
// assumes an APB master on pclk and a tape interface on the same clock
`timescale 1ns/1ps
`default_nettype none
module tch_core
	import tch_pkg::*;
(
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// host interrupt
	output logic              host_irq,
	// tape interface
	output tch_tif_req_t      tif_req,
	output logic              tif_req_valid,
	input  wire logic         tif_req_ack,
	input  wire logic         tif_done,
	input  wire logic [95:0]  tif_stat,
	input  wire logic         tif_off_done,
	input  wire logic [1:0]   tif_off_unit,
	input  wire logic [95:0]  tif_off_stat,
	output logic              tif_media_watch,
	// disk and flexible controls
	output logic              dsk_retry_inhibit,
	output logic              dsk_skip_ram_test,
	output logic              flx_deleted_data,
	output logic              flx_motor_on,
	output logic              diag_cksum_only,
	output logic              diag_restore_only,
	output logic [23:0]       buf_addr
);
	// op status summary of a 12-byte status buffer
	function automatic logic [7:0] opsum(input logic [95:0] b,
		input logic [1:0] u);
		logic       hard;
		logic       any;
		logic [3:0] code;
		hard = |b[15:0];
		any  = |b[23:0];
		code = {|b[71:64], |b[55:48], |b[47:40], |b[31:24]};
		opsum = {any, hard, u, code};
	endfunction

	// software visible registers and internal command state
	logic [31:0]  param_ff;
	logic [15:0]  mod_ff;
	logic [31:0]  bufptr_ff;
	logic [7:0]   opstat_ff;
	logic         flag_ff;
	logic         host_irq_ff;
	logic [95:0]  short_ff;
	logic [95:0]  long_ff;
	logic         off_pend_ff;
	logic [1:0]   off_unit_ff;
	logic         media_ff;
	logic         wr_dir_ff;
	logic [31:0]  prdata_ff;
	logic [23:0]  buf_addr_ff;
	tch_state_t   st_ff;
	tch_state_t   nxt_st;
	tch_tif_req_t req_ff;
	logic [7:0]   cur_fn_ff;
	logic [1:0]   cur_unit_ff;

	// apb decode
	wire        wr_acc   = psel & penable & pwrite;
	wire        rd_setup = psel & ~penable & ~pwrite;
	wire        adr_ok   = (paddr[1:0] == 2'b00) && (paddr <= 8'h28);
	wire        wr_param = wr_acc & (paddr == ADR_PARAM);
	wire        wr_mod   = wr_acc & (paddr == ADR_MODIFY);
	wire        wr_ptr   = wr_acc & (paddr == ADR_BUFPTR);
	wire        start_w  = wr_acc & (paddr == ADR_CMD) & pwdata[0]
	                       & (st_ff == ST_IDLE);
	wire        flag_clr = wr_acc & (paddr == ADR_OPSTAT)
	                       & pwdata[OPS_FLAG];
	wire        busy     = (st_ff != ST_IDLE);

	// parameter fields of the current command
	wire [15:0] dev_code = param_ff[15:0];
	wire [1:0]  unit_w   = param_ff[17:16];
	wire [7:0]  fn_w     = param_ff[31:24];
	wire        is_tape  = (dev_code == DEV_TAPE);
	wire        is_xstat = (fn_w == FN_XSTAT);
	wire        is_long  = (fn_w == FN_RETEN) | (fn_w == FN_REWIND)
	                       | (fn_w == FN_SPACEFM) | (fn_w == FN_ERASE);
	wire        supp     = mod_ff[MOD_SUPP];
	wire        xlong    = mod_ff[MOD_LONG];

	// off-line completion posts only in idle with host flag clear
	wire off_go = (st_ff == ST_IDLE) & off_pend_ff & ~flag_ff
	              & ~start_w;

	// read data selection
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		case (paddr)
			ADR_PARAM:  rd_mux = param_ff;
			ADR_MODIFY: rd_mux = {16'h0, mod_ff};
			ADR_BUFPTR: rd_mux = bufptr_ff;
			ADR_OPSTAT: rd_mux = {21'h0, off_pend_ff, busy, flag_ff,
			                      opstat_ff};
			8'h14:      rd_mux = short_ff[31:0];
			8'h18:      rd_mux = short_ff[63:32];
			8'h1c:      rd_mux = short_ff[95:64];
			8'h20:      rd_mux = long_ff[31:0];
			8'h24:      rd_mux = long_ff[63:32];
			8'h28:      rd_mux = long_ff[95:64];
			default:    rd_mux = 32'h0;
		endcase
	end

	// state sequencing
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE: begin
				if (start_w) begin
					nxt_st = (is_tape && !is_xstat) ? ST_ISSUE : ST_POST;
				end
			end
			ST_ISSUE: begin
				if (tif_req_ack) begin
					nxt_st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (tif_done) begin
					nxt_st = ST_POST;
				end
			end
			ST_POST: nxt_st = ST_IDLE;
			default: nxt_st = ST_IDLE;
		endcase
	end

	// request fields to the tape interface
	tch_tif_req_t nxt_req;
	always_comb begin
		nxt_req          = '0;
		nxt_req.code     = fn_w;
		nxt_req.unit     = unit_w;
		nxt_req.offline  = is_long;
		nxt_req.fm_write = (fn_w == FN_TERM) & wr_dir_ff;
		nxt_req.rewind   = (fn_w == FN_TERM) & ~wr_dir_ff;
	end

	// pointer: linear or segment*16 plus offset
	wire [23:0] seg_addr = {4'h0, bufptr_ff[31:16], 4'h0}
	                       + {8'h0, bufptr_ff[15:0]};
	wire [23:0] nxt_buf_addr = mod_ff[MOD_LIN] ? bufptr_ff[23:0]
	                           : seg_addr;

	// apb registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			param_ff  <= 32'h0;
			mod_ff    <= 16'h0;
			bufptr_ff <= 32'h0;
			prdata_ff <= 32'h0;
		end else begin
			if (wr_param) param_ff <= pwdata;
			if (wr_mod) mod_ff <= pwdata[15:0];
			if (wr_ptr) bufptr_ff <= pwdata;
			if (rd_setup) prdata_ff <= rd_mux;
		end
	end

	// command state and request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff       <= ST_IDLE;
			req_ff      <= '0;
			cur_fn_ff   <= 8'h0;
			cur_unit_ff <= 2'b00;
			wr_dir_ff   <= 1'b0;
			buf_addr_ff <= 24'h0;
		end else begin
			st_ff       <= nxt_st;
			buf_addr_ff <= nxt_buf_addr;
			if (start_w) begin
				req_ff      <= nxt_req;
				cur_fn_ff   <= fn_w;
				cur_unit_ff <= unit_w;
				if (is_tape && fn_w == FN_WRDATA) wr_dir_ff <= 1'b1;
				if (is_tape && fn_w == FN_RDDATA) wr_dir_ff <= 1'b0;
			end
		end
	end

	// short-term buffer source at start of a status transfer or non-tape command
	wire [95:0] start_stat = !is_xstat ? STAT_BADFN
	                         : xlong ? long_ff : short_ff;

	// status buffers, op status, flag and interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			short_ff    <= STAT_RST;
			long_ff     <= STAT_RST;
			opstat_ff   <= OPSTAT_RST;
			flag_ff     <= 1'b0;
			host_irq_ff <= 1'b0;
			off_pend_ff <= 1'b0;
			off_unit_ff <= 2'b00;
			media_ff    <= 1'b0;
		end else begin
			if (start_w && !(is_tape && !is_xstat)) begin
				short_ff <= start_stat;
			end
			if (st_ff == ST_WAIT && tif_done) begin
				short_ff <= tif_stat;
			end
			// host clear first, any post in this cycle overrides it
			if (flag_clr) begin
				flag_ff     <= 1'b0;
				host_irq_ff <= 1'b0;
			end
			if (st_ff == ST_POST) begin
				opstat_ff <= opsum(short_ff, cur_unit_ff);
				flag_ff   <= 1'b1;
				if (!supp) host_irq_ff <= 1'b1;
				if (cur_fn_ff == FN_LOAD) media_ff <= 1'b1;
				if (cur_fn_ff == FN_TRESET) media_ff <= 1'b0;
			end
			if (off_go) begin
				opstat_ff   <= opsum(long_ff, off_unit_ff);
				flag_ff     <= 1'b1;
				host_irq_ff <= 1'b1;
				off_pend_ff <= 1'b0;
			end
			// a new off-line end wins over the clear of the old one
			if (tif_off_done) begin
				long_ff     <= tif_off_stat;
				off_unit_ff <= tif_off_unit;
				off_pend_ff <= 1'b1;
			end
		end
	end

	// outputs
	assign prdata            = prdata_ff;
	assign pready            = 1'b1;
	assign pslverr           = psel & penable & ~adr_ok;
	assign host_irq          = host_irq_ff;
	assign tif_req           = req_ff;
	assign tif_req_valid     = (st_ff == ST_ISSUE);
	assign tif_media_watch   = media_ff;
	assign buf_addr          = buf_addr_ff;

	// modifier driven controls
	assign dsk_retry_inhibit = mod_ff[MOD_NORTY];
	assign dsk_skip_ram_test = mod_ff[MOD_BYPAS]
	                           & (dev_code == DEV_HARD)
	                           & (fn_w == FN_INIT)
	                           & (unit_w == 2'b00);
	assign flx_deleted_data  = mod_ff[MOD_DELDT];
	assign flx_motor_on      = mod_ff[MOD_MOTOR]
	                           & (dev_code == DEV_FLEX);
	assign diag_cksum_only   = mod_ff[MOD_CKSUM]
	                           & (fn_w == FN_DIAG);
	assign diag_restore_only = mod_ff[MOD_RESTR]
	                           & (fn_w == FN_DIAG);

	// checks
	a_opstat_post: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff == ST_POST) |=> (opstat_ff == opsum($past(short_ff),
		$past(cur_unit_ff))))
		else $error("op status not condensed at post");
	a_opstat_any_bit: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_ff == ST_POST) |=>
		opstat_ff[7] == (($past(short_ff) & 96'hff_ffff) != 96'h0))
		else $error("any-error bit disagrees with status bytes");
	a_hard_any: assert property (@(posedge pclk) disable iff (!presetn)
		opstat_ff[6] |-> opstat_ff[7])
		else $error("hard error without any-error bit");
	a_supp_short: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_ff == ST_POST) && supp && !host_irq_ff |=> !host_irq_ff)
		else $error("suppressed interrupt raised");
	a_offline_irq: assert property (@(posedge pclk)
		disable iff (!presetn)
		off_go |=> host_irq_ff && flag_ff && (opstat_ff ==
		opsum($past(long_ff), $past(off_unit_ff))))
		else $error("off-line completion not posted");
	a_offline_wait: assert property (@(posedge pclk)
		disable iff (!presetn)
		off_pend_ff && flag_ff && !flag_clr && (st_ff == ST_IDLE)
		|=> $stable(opstat_ff))
		else $error("off-line status posted over a set flag");
	a_long_xfer: assert property (@(posedge pclk)
		disable iff (!presetn)
		start_w && is_xstat && xlong && !tif_off_done
		|=> short_ff == long_ff ##1 flag_ff)
		else $error("long buffer not moved to short buffer");
	a_term_mode: assert property (@(posedge pclk)
		disable iff (!presetn)
		tif_req_valid && (tif_req.code == FN_TERM) |->
		(tif_req.fm_write != tif_req.rewind))
		else $error("terminate mode not exactly one action");
	a_req_hold: assert property (@(posedge pclk)
		disable iff (!presetn)
		tif_req_valid && !tif_req_ack |=> tif_req_valid && $stable(tif_req))
		else $error("tape request dropped before ack");
	a_irq_flag: assert property (@(posedge pclk)
		disable iff (!presetn)
		host_irq_ff |-> flag_ff)
		else $error("interrupt without status flag");

	// status posting checks
	a_post_flag: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_ff == ST_POST) |=> flag_ff)
		else $error("post did not raise the status flag");
	a_post_irq: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_ff == ST_POST) && !supp |=> host_irq_ff)
		else $error("unsuppressed completion without interrupt");
	a_done_capture: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_ff == ST_WAIT) && tif_done |=> (short_ff == $past(tif_stat)))
		else $error("drive status not copied at tape end");
	a_load_watch: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_ff == ST_POST) && (cur_fn_ff == FN_LOAD) |=> media_ff)
		else $error("medium watch not started by load");
	a_treset_watch: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_ff == ST_POST) && (cur_fn_ff == FN_TRESET) |=> !media_ff)
		else $error("medium watch kept after tape reset");

	// tape request checks
	a_issue_tape: assert property (@(posedge pclk)
		disable iff (!presetn)
		start_w && is_tape && !is_xstat |=> tif_req_valid)
		else $error("tape function not sent to the interface");
	a_xstat_post: assert property (@(posedge pclk)
		disable iff (!presetn)
		start_w && is_xstat |=> (st_ff == ST_POST))
		else $error("status transfer did not post at once");
	a_reten_offline: assert property (@(posedge pclk)
		disable iff (!presetn)
		tif_req_valid && (tif_req.code == FN_RETEN) |-> tif_req.offline)
		else $error("retension not sent as off-line");
	a_term_short: assert property (@(posedge pclk)
		disable iff (!presetn)
		tif_req_valid && (tif_req.code == FN_TERM) |-> !tif_req.offline)
		else $error("terminate sent as off-line");

	// off-line completion and flag checks
	a_offline_pend: assert property (@(posedge pclk)
		disable iff (!presetn)
		tif_off_done |=> off_pend_ff)
		else $error("off-line end not held pending");
	a_long_keep: assert property (@(posedge pclk)
		disable iff (!presetn)
		!tif_off_done |=> $stable(long_ff))
		else $error("long buffer changed without off-line end");
	a_flag_clear: assert property (@(posedge pclk)
		disable iff (!presetn)
		flag_clr && (st_ff != ST_POST) && !off_go |=>
		!flag_ff && !host_irq_ff)
		else $error("host clear did not drop flag and interrupt");
endmodule
`default_nettype wire

// *** verif/tch_tape_model.sv ***
// tape interface model: acks requests, reports drive status
// assumes the core on the same clock; bench sets status and pacing
`timescale 1ns/1ps
`default_nettype none
module tch_tape_model
	import tch_pkg::*;
(
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// core side
	input  wire tch_tif_req_t tif_req,
	input  wire logic         tif_req_valid,
	output logic              tif_req_ack,
	output logic              tif_done,
	output logic [95:0]       tif_stat,
	output logic              tif_off_done,
	output logic [1:0]        tif_off_unit,
	output logic [95:0]       tif_off_stat,
	// bench controls
	input  wire logic         slow,
	input  wire logic         off_go,
	input  wire logic [95:0]  st_val,
	input  wire logic [95:0]  off_val,
	output tch_tif_req_t      last_req
);
	// one request at a time: ack, then end with drive status
	initial begin
		tif_req_ack = 1'b0;
		tif_done = 1'b0;
		tif_stat = '0;
		last_req = '0;
		forever begin
			@(posedge pclk);
			if (presetn === 1'b1 && tif_req_valid === 1'b1) begin
				repeat (slow ? 3 : 0) @(posedge pclk);
				tif_req_ack <= 1'b1;
				last_req <= tif_req;
				@(posedge pclk);
				tif_req_ack <= 1'b0;
				repeat (slow ? 4 : 0) @(posedge pclk);
				tif_done <= 1'b1;
				tif_stat <= st_val;
				@(posedge pclk);
				tif_done <= 1'b0;
				tif_stat <= ~st_val; // status no longer held
			end
		end
	end
	// off-line part ends when the bench says so
	always @(posedge pclk) begin
		tif_off_done <= off_go;
		tif_off_unit <= last_req.unit;
		tif_off_stat <= off_go ? off_val : ~tif_off_stat;
	end
endmodule
`default_nettype wire

// *** verif/tch_core_test.sv ***
// self-checking bench of the tape command and status handler
// assumes the tape interface model beside the core, one clock
`timescale 1ns/1ps
`default_nettype none
module tch_core_test;
	import tch_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, perr, wr;
	logic [7:0]   paddr, fn;
	logic [31:0]  pwdata, prdata, r, t, mod;
	logic         pready, pslverr, host_irq, tif_req_valid, tif_req_ack;
	logic         tif_done, tif_off_done, tif_media_watch, off_go, slow;
	logic [1:0]   tif_off_unit, u;
	logic [95:0]  tif_stat, tif_off_stat, st_val, off_val;
	wire logic [5:0] ctl;
	logic [5:0]   e;
	logic [23:0]  buf_addr, ea;
	tch_tif_req_t tif_req, last_req;
	logic [31:0]  seed = 32'h17a1;
	logic [7:0]   fns [7] = '{FN_LOAD, FN_TRESET, FN_RDSTAT, FN_WRDATA,
		FN_TERM, FN_RDDATA, FN_TERM};
	int           fail_count = 0;
	int           n_compared = 0;
	int           cycles = 0;
	tch_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .host_irq(host_irq), .tif_req(tif_req),
		.tif_req_valid(tif_req_valid), .tif_req_ack(tif_req_ack),
		.tif_done(tif_done), .tif_stat(tif_stat),
		.tif_off_done(tif_off_done), .tif_off_unit(tif_off_unit),
		.tif_off_stat(tif_off_stat), .tif_media_watch(tif_media_watch),
		.dsk_retry_inhibit(ctl[5]), .dsk_skip_ram_test(ctl[4]),
		.flx_deleted_data(ctl[3]), .flx_motor_on(ctl[2]),
		.diag_cksum_only(ctl[1]), .diag_restore_only(ctl[0]),
		.buf_addr(buf_addr));
	tch_tape_model tape (.pclk(pclk), .presetn(presetn),
		.tif_req(tif_req), .tif_req_valid(tif_req_valid),
		.tif_req_ack(tif_req_ack), .tif_done(tif_done),
		.tif_stat(tif_stat), .tif_off_done(tif_off_done),
		.tif_off_unit(tif_off_unit), .tif_off_stat(tif_off_stat),
		.slow(slow), .off_go(off_go), .st_val(st_val),
		.off_val(off_val), .last_req(last_req));
	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("BAD %0t run did not finish", $time);
			summarize();
		end
	end
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected op status byte from a status buffer
	function automatic logic [7:0] opx(input logic [95:0] s,
		input logic [1:0] un);
		return {|s[23:0], |s[15:0], un, s[71:64] != 8'h00,
			s[55:48] != 8'h00, s[47:40] != 8'h00, s[31:24] != 8'h00};
	endfunction
	task automatic chk(input logic [31:0] got, exp, input string m);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one apb transfer, result left in r and perr
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic issue(input logic [1:0] un, input logic [31:0] m);
		apb(1'b1, ADR_PARAM, {fn, 6'h00, un, DEV_TAPE});
		apb(1'b1, ADR_MODIFY, m);
		apb(1'b1, ADR_CMD, 32'h1);
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, ADR_OPSTAT, 32'h0);
			if (r[OPS_FLAG] === 1'b1)
				break;
		end
	endtask
	task automatic bufchk(input logic [7:0] a, input logic [95:0] s);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, a + 8'(4 * i), 32'h0);
			chk(r, s[32 * i +: 32], "status buffer word");
		end
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, off_go, slow, wr} = '0;
		paddr = '0;
		pwdata = '0;
		st_val = '0;
		off_val = '0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// reset value and an unmapped address
		apb(1'b0, ADR_OPSTAT, 32'h0);
		chk(r, 32'h0, "opstat after reset");
		apb(1'b0, 8'h2c, 32'h0);
		chk({31'h0, perr}, 32'h1, "unmapped access");
		// short-term tape functions with random drive status
		for (int k = 0; k < 7; k++) begin
			fn = fns[k];
			t = xs();
			u = t[1:0];
			slow = t[2];
			st_val = {xs(), xs(), xs()} & (k % 3 == 0 ? ~96'hffffff :
				k % 3 == 1 ? ~96'hffff : ~96'h0);
			issue(u, 32'h0);
			chk({31'h0, host_irq}, 32'h1, "completion irq");
			chk(r[7:0], opx(st_val, u), "op status");
			bufchk(ADR_SHORT0, st_val);
			chk({last_req.unit, last_req.code}, {u, fn}, "request");
			chk({last_req.offline, last_req.fm_write, last_req.rewind},
				{1'b0, fn == FN_TERM && wr, fn == FN_TERM && !wr},
				"request flags");
			if (fn == FN_LOAD)
				chk({31'h0, tif_media_watch}, 32'h1, "watch");
			if (fn == FN_TRESET)
				chk({31'h0, tif_media_watch}, 32'h0, "watch");
			wr = fn == FN_WRDATA ? 1'b1 : fn == FN_RDDATA ? 1'b0 : wr;
			apb(1'b1, ADR_OPSTAT, 32'h100);
			#1;
			chk({31'h0, host_irq}, 32'h0, "irq cleared");
		end
		// retension, first irq suppressed, off-line end held back
		fn = FN_RETEN;
		st_val = {xs(), xs(), xs()};
		off_val = {xs(), xs(), xs()};
		issue(2'd2, 32'h1 << MOD_SUPP);
		chk(r[7:0], opx(st_val, 2'd2), "start status");
		chk({31'h0, host_irq}, 32'h0, "first irq");
		chk({31'h0, last_req.offline}, 32'h1, "off-line");
		off_go <= 1'b1;
		@(posedge pclk);
		off_go <= 1'b0;
		apb(1'b0, ADR_OPSTAT, 32'h0);
		chk({29'h0, r[10:8]}, 32'h5, "held completion");
		bufchk(ADR_LONG0, off_val);
		apb(1'b1, ADR_OPSTAT, 32'h100);
		repeat (2) @(posedge pclk);
		#1;
		chk({31'h0, host_irq}, 32'h1, "second irq");
		apb(1'b0, ADR_OPSTAT, 32'h0);
		chk(r[10:0], {3'b001, opx(off_val, 2'd2)}, "off status");
		apb(1'b1, ADR_OPSTAT, 32'h100);
		// status transfer of the long buffer over the short one
		fn = FN_XSTAT;
		issue(2'd0, 32'h1 << MOD_LONG);
		bufchk(ADR_SHORT0, off_val);
		apb(1'b1, ADR_OPSTAT, 32'h100);
		// modifier controls and buffer pointer forms
		for (int k = 0; k < 8; k++) begin
			mod = xs();
			t = xs();
			fn = k[0] ? FN_DIAG : FN_INIT;
			u = {1'b0, k[2]};
			if (mod[MOD_LIN])
				t[31:24] = 8'h00;
			apb(1'b1, ADR_PARAM, {fn, 6'h00, u, k[1] ? DEV_FLEX : DEV_HARD});
			apb(1'b1, ADR_MODIFY, mod);
			apb(1'b1, ADR_BUFPTR, t);
			repeat (2) @(posedge pclk);
			#1;
			e = {mod[MOD_NORTY], mod[MOD_BYPAS] & !k[1] & !k[0] & !k[2],
				mod[MOD_DELDT], mod[MOD_MOTOR] & k[1],
				mod[MOD_CKSUM] & k[0], mod[MOD_RESTR] & k[0]};
			chk(ctl, e, "controls");
			ea = mod[MOD_LIN] ? t[23:0] : {t[31:16], 4'h0} + {8'h0, t[15:0]};
			chk({8'h0, buf_addr}, {8'h0, ea}, "buffer address");
		end
		summarize();
	end
endmodule
`default_nettype wire
